// ---- rtl/cps_pkg.sv ----
/*
  Constants, types and register map for the configurable status pin block.
  Assumes a single 200 MHz clock and a plain strobe-based register port.
*/
// Notes on behaviour
// - Line driver enable rises exactly one bit period before each start bit.
// - Line driver enable falls when the stop bit begins, no trailing delay.
// - Line driver enable is high only during the lead bit period and while a character is being sent.
// - Active-low power enable is inactive (high) during suspend.
// - Sleep indicator pin is high when active, low in suspend.
// - Bit period never shorter than 3 Mbaud allows, whatever software writes.
// - Detect a dedicated charging port instead of an enumerating host.
// - Charger detect output asserts once a charging port is found and suspended.
// - Charger detect is also selectable in active-low form on a pin.
// - Shorted data lines from a charging port put the block in suspend.
// - Enumerated by a host means not suspended; charger detect held inactive.
// - Activity LED pins float when idle and drive low during activity.
// - Each activity indication is stretched by a digital one-shot.
// - A combined option shows transmit or receive activity on one pin.
// - Any pin can take transmit, receive or combined activity function.
// - Power enable is high whenever the block is in suspend.
// - Sleep indicator goes low whenever the block enters suspend.
package cps_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_HZ       = 200_000_000;
  localparam int MAX_BAUD     = 3_000_000;
  localparam int MIN_DIV      = (CLK_HZ + MAX_BAUD - 1) / MAX_BAUD;
  localparam int RST_BAUD     = 9600;
  localparam int RST_DIV      = CLK_HZ / RST_BAUD;
  localparam int DCP_WIN_US   = 10;
  localparam int DCP_WIN_CYC  = DCP_WIN_US * (CLK_HZ / 1_000_000);
  localparam int LED_HOLD_MS  = 10;
  localparam int LED_HOLD_CYC = LED_HOLD_MS * (CLK_HZ / 1000);

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int DIV_W    = 16;
  localparam int CFG_W    = 4;
  localparam int MAX_PINS = 4;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_PIN_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BAUD    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h08;

  localparam int ST_SUSP_BIT = 0;
  localparam int ST_DCP_BIT  = 1;
  localparam int ST_CHG_BIT  = 2;
  localparam int ST_LDE_BIT  = 3;
  localparam int ST_ENUM_BIT = 4;

  // ****************************************************************
  // Pin functions
  // ****************************************************************
  typedef enum logic [CFG_W-1:0] {
    FN_TRISTATE,
    FN_LINE_DRV,
    FN_PWR_EN_N,
    FN_SLEEP_N,
    FN_CHG,
    FN_CHG_N,
    FN_TX_LED,
    FN_RX_LED,
    FN_TXRX_LED
  } cps_func_e;

  localparam logic [MAX_PINS*CFG_W-1:0] RST_PIN_CFG =
    {FN_SLEEP_N, FN_TX_LED, FN_RX_LED, FN_LINE_DRV};

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cps_reg_req_s;

  typedef struct packed {
    logic vbus;
    logic suspend;
    logic enumerated;
    logic dm_level;
  } cps_usb_s;

endpackage

// ---- rtl/cps_one_shot.sv ----
/*
  Retriggerable one-shot used to stretch activity pulses for LEDs.
  Assumes the trigger is synchronous to clk.
*/
`timescale 1ns/1ps
module cps_one_shot #(
  parameter int HOLD_CYC = 2_000_000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Trigger and stretched output
  input  wire logic trig,
  output logic      active
);

  localparam int CNT_W = $clog2(HOLD_CYC + 1);
  localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYC);

  logic [CNT_W-1:0] cnt_reg;

  generate
    if (HOLD_CYC < 1) begin : g_bad
      $error("cps_one_shot: HOLD_CYC must be at least 1");
    end
  endgenerate

  // Any new activity reloads the full hold time.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (trig) begin
      cnt_reg <= HOLD_LOAD;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
    end else begin
      active <= trig | (cnt_reg > 1);
    end
  end

endmodule

// ---- rtl/cps_pins.sv ----
/*
  Status outputs for the configurable I/O pins: line driver enable timed to
  each character, suspend indicators, charging port detection and stretched
  activity LED drives, plus a small register port.
  Assumes the UART datapath, USB engine and pin pads sit outside this block.
*/
`timescale 1ns/1ps
module cps_pins #(
  parameter int NUM_PINS     = 4,
  parameter int LED_HOLD_CYC = cps_pkg::LED_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  // Register port
  input  wire cps_pkg::cps_reg_req_s          reg_req,
  output logic [cps_pkg::DATA_W-1:0]          reg_rdata,
  // UART transmit handshake
  input  wire logic                           tx_char_req,
  input  wire logic                           tx_stop_bit,
  output logic                                tx_char_go,
  output logic [cps_pkg::DIV_W-1:0]           baud_div,
  // Activity pulses
  input  wire logic                           tx_activity,
  input  wire logic                           rx_activity,
  // USB status and charging port probe
  input  wire cps_pkg::cps_usb_s              usb,
  output logic                                dcp_probe_en,
  // Configurable pins
  output logic [NUM_PINS-1:0]                 cio_out,
  output logic [NUM_PINS-1:0]                 cio_oe
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int DCP_CNT_W = $clog2(cps_pkg::DCP_WIN_CYC + 1);
  localparam logic [DCP_CNT_W-1:0] DCP_LAST = DCP_CNT_W'(cps_pkg::DCP_WIN_CYC - 1);
  localparam logic [cps_pkg::DIV_W-1:0] MIN_DIV = cps_pkg::DIV_W'(cps_pkg::MIN_DIV);
  localparam logic [cps_pkg::DIV_W-1:0] RST_DIV = cps_pkg::DIV_W'(cps_pkg::RST_DIV);

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_LEAD,
    TX_SEND
  } cps_tx_e;

  typedef enum logic [1:0] {
    DCP_IDLE,
    DCP_PROBE,
    DCP_FOUND,
    DCP_HOST
  } cps_dcp_e;

  cps_tx_e                             tx_state_reg;
  cps_dcp_e                            dcp_state_reg;
  logic [cps_pkg::DIV_W-1:0]           lead_cnt_reg;
  logic [DCP_CNT_W-1:0]                dcp_cnt_reg;
  logic [NUM_PINS*cps_pkg::CFG_W-1:0]  pin_cfg_reg;
  logic                                line_drv_reg;
  logic                                suspended_reg;
  logic                                charger_reg;
  logic [2:0]                          led_trig;
  logic [2:0]                          led_on;
  logic [NUM_PINS-1:0]                 cio_out_next;
  logic [NUM_PINS-1:0]                 cio_oe_next;
  logic [cps_pkg::DIV_W-1:0]           div_wr;
  logic [cps_pkg::DATA_W-1:0]          status_word;

  generate
    if (NUM_PINS < 1 || NUM_PINS > cps_pkg::MAX_PINS) begin : g_bad_pins
      $error("cps_pins: NUM_PINS must be 1 to 4");
    end
    if (LED_HOLD_CYC < 1) begin : g_bad_hold
      $error("cps_pins: LED_HOLD_CYC must be at least 1");
    end
  endgenerate

  // ****************************************************************
  // Register writes
  // ****************************************************************
  assign div_wr = reg_req.wdata[cps_pkg::DIV_W-1:0];

  // Pin codes start from the non-volatile defaults at reset.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_cfg_reg <= cps_pkg::RST_PIN_CFG[NUM_PINS*cps_pkg::CFG_W-1:0];
    end else if (reg_req.wr && reg_req.addr == cps_pkg::OFS_PIN_CFG) begin
      pin_cfg_reg <= reg_req.wdata[NUM_PINS*cps_pkg::CFG_W-1:0];
    end
  end

  // A divisor below the 3 Mbaud limit is clamped rather than refused, so the
  // line never runs faster than the transceivers were promised.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      baud_div <= RST_DIV;
    end else if (reg_req.wr && reg_req.addr == cps_pkg::OFS_BAUD) begin
      baud_div <= (div_wr < MIN_DIV) ? MIN_DIV : div_wr;
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_comb begin
    status_word = '0;
    status_word[cps_pkg::ST_SUSP_BIT] = suspended_reg;
    status_word[cps_pkg::ST_DCP_BIT]  = (dcp_state_reg == DCP_FOUND);
    status_word[cps_pkg::ST_CHG_BIT]  = charger_reg;
    status_word[cps_pkg::ST_LDE_BIT]  = line_drv_reg;
    status_word[cps_pkg::ST_ENUM_BIT] = usb.enumerated;
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give 0.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        cps_pkg::OFS_PIN_CFG: reg_rdata <= cps_pkg::DATA_W'(pin_cfg_reg);
        cps_pkg::OFS_BAUD:    reg_rdata <= cps_pkg::DATA_W'(baud_div);
        cps_pkg::OFS_STATUS:  reg_rdata <= status_word;
        default:              reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ****************************************************************
  // Line driver enable sequencer
  // ****************************************************************
  // The enable leads the start bit by one full bit period: the sequencer
  // holds the character back that long before telling the UART to go.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_state_reg <= TX_IDLE;
      lead_cnt_reg <= '0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_char_req) begin
            tx_state_reg <= TX_LEAD;
            lead_cnt_reg <= baud_div;
          end
        end
        TX_LEAD: begin
          if (lead_cnt_reg == '0) begin
            tx_state_reg <= TX_SEND;
          end else begin
            lead_cnt_reg <= lead_cnt_reg - 1'b1;
          end
        end
        TX_SEND: begin
          if (tx_stop_bit) begin
            tx_state_reg <= TX_IDLE;
          end
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      line_drv_reg <= 1'b0;
    end else if (tx_state_reg == TX_IDLE) begin
      line_drv_reg <= tx_char_req;
    end else if (tx_state_reg == TX_SEND && tx_stop_bit) begin
      line_drv_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_char_go <= 1'b0;
    end else begin
      tx_char_go <= (tx_state_reg == TX_LEAD) && (lead_cnt_reg == '0);
    end
  end

  // ****************************************************************
  // Charging port detection
  // ****************************************************************
  // With the probe driving the positive data line, a charging port shorts it
  // to the negative line; a host leaves that line low and enumerates instead.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dcp_state_reg <= DCP_IDLE;
      dcp_cnt_reg   <= '0;
    end else if (!usb.vbus) begin
      dcp_state_reg <= DCP_IDLE;
      dcp_cnt_reg   <= '0;
    end else begin
      case (dcp_state_reg)
        DCP_IDLE: begin
          dcp_state_reg <= DCP_PROBE;
          dcp_cnt_reg   <= '0;
        end
        DCP_PROBE: begin
          if (usb.enumerated || !usb.dm_level) begin
            dcp_state_reg <= DCP_HOST;
          end else if (dcp_cnt_reg == DCP_LAST) begin
            dcp_state_reg <= DCP_FOUND;
          end else begin
            dcp_cnt_reg <= dcp_cnt_reg + 1'b1;
          end
        end
        DCP_FOUND: begin
          if (usb.enumerated) begin
            dcp_state_reg <= DCP_HOST;
          end
        end
        DCP_HOST: begin
          dcp_state_reg <= DCP_HOST;
        end
        default: begin
          dcp_state_reg <= DCP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dcp_probe_en <= 1'b0;
    end else begin
      dcp_probe_en <= usb.vbus && (dcp_state_reg == DCP_IDLE || dcp_state_reg == DCP_PROBE);
    end
  end

  // ****************************************************************
  // Suspend and charger state
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      suspended_reg <= 1'b0;
    end else begin
      suspended_reg <= !usb.enumerated &&
                       (usb.suspend || dcp_state_reg == DCP_FOUND);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      charger_reg <= 1'b0;
    end else begin
      charger_reg <= (dcp_state_reg == DCP_FOUND) && suspended_reg &&
                     !usb.enumerated;
    end
  end

  // ****************************************************************
  // Activity stretching
  // ****************************************************************
  assign led_trig = {tx_activity | rx_activity, rx_activity, tx_activity};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_led
      cps_one_shot #(
        .HOLD_CYC (LED_HOLD_CYC)
      ) u_one_shot (
        .clk    (sys_clk),
        .rst    (rst),
        .trig   (led_trig[gi]),
        .active (led_on[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Pin function selection
  // ****************************************************************
  // Codes outside the function list leave the pin floating, so a corrupted
  // configuration cannot fight whatever is wired to the pin.
  always_comb begin
    cio_out_next = '0;
    cio_oe_next  = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      case (cps_pkg::cps_func_e'(pin_cfg_reg[i*cps_pkg::CFG_W +: cps_pkg::CFG_W]))
        cps_pkg::FN_LINE_DRV: begin
          cio_out_next[i] = line_drv_reg;
          cio_oe_next[i]  = 1'b1;
        end
        cps_pkg::FN_PWR_EN_N: begin
          cio_out_next[i] = suspended_reg;
          cio_oe_next[i]  = 1'b1;
        end
        cps_pkg::FN_SLEEP_N: begin
          cio_out_next[i] = !suspended_reg;
          cio_oe_next[i]  = 1'b1;
        end
        cps_pkg::FN_CHG: begin
          cio_out_next[i] = charger_reg;
          cio_oe_next[i]  = 1'b1;
        end
        cps_pkg::FN_CHG_N: begin
          cio_out_next[i] = !charger_reg;
          cio_oe_next[i]  = 1'b1;
        end
        cps_pkg::FN_TX_LED: begin
          cio_oe_next[i] = led_on[0];
        end
        cps_pkg::FN_RX_LED: begin
          cio_oe_next[i] = led_on[1];
        end
        cps_pkg::FN_TXRX_LED: begin
          cio_oe_next[i] = led_on[2];
        end
        default: begin
          cio_oe_next[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cio_out <= '0;
      cio_oe  <= '0;
    end else begin
      cio_out <= cio_out_next;
      cio_oe  <= cio_oe_next;
    end
  end

endmodule

// ---- dv/cps_pins_props.sv ----
/*
  Concurrent checks on the ports of the configurable status pin block.
  Assumes pin configuration is only rewritten while the pins are quiet.
*/
`timescale 1ns/1ps
module cps_pins_props #(
  parameter int NUM_PINS     = 4,
  parameter int LED_HOLD_CYC = 8
) (
  // Clock and reset
  input wire logic                         sys_clk,
  input wire logic                         rst,
  // Register port
  input wire cps_pkg::cps_reg_req_s        reg_req,
  input wire logic [cps_pkg::DATA_W-1:0]   reg_rdata,
  // Transmit handshake
  input wire logic                         tx_char_req,
  input wire logic                         tx_stop_bit,
  input wire logic                         tx_char_go,
  input wire logic [cps_pkg::DIV_W-1:0]    baud_div,
  // Activity, USB and pins
  input wire logic                         tx_activity,
  input wire logic                         rx_activity,
  input wire cps_pkg::cps_usb_s            usb,
  input wire logic                         dcp_probe_en,
  input wire logic [NUM_PINS-1:0]          cio_out,
  input wire logic [NUM_PINS-1:0]          cio_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Helper state
  // ****************************************************************
  logic [15:0]         cfg_q;
  logic [15:0]         lead_cnt;
  logic                sent;
  logic [11:0]         dcp_cnt;
  logic                bad;
  wire [NUM_PINS-1:0]  ld_m, pwr_m, slp_m, chg_m, chgn_m;
  wire                 ld = |(cio_out & ld_m);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) cfg_q <= cps_pkg::RST_PIN_CFG;
    else if (reg_req.wr && reg_req.addr == cps_pkg::OFS_PIN_CFG) cfg_q <= reg_req.wdata[15:0];
  end
  // Cycles the line driver pin has been high; the lead is judged at go.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) lead_cnt <= '0;
    else lead_cnt <= ld ? lead_cnt + 16'h1 : '0;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) sent <= 1'b0;
    else if (tx_char_go) sent <= 1'b1;
    else if (tx_stop_bit) sent <= 1'b0;
  end
  // A probe that ever saw D- low or enumeration marks a host port.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dcp_cnt <= '0;
      bad     <= 1'b0;
    end else if (!usb.vbus) begin
      dcp_cnt <= '0;
      bad     <= 1'b0;
    end else begin
      if (dcp_cnt != 12'hfff) dcp_cnt <= dcp_cnt + 12'h1;
      if (dcp_probe_en && (!usb.dm_level || usb.enumerated)) bad <= 1'b1;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence s_drop;
    ##1 ld ##1 !ld;
  endsequence
  sequence s_susp;
    (usb.suspend && !usb.enumerated) [*3];
  endsequence
  property p_baud_floor;
    baud_div >= cps_pkg::MIN_DIV;
  endproperty
  property p_lead;
    tx_char_go && ld_m != 0 |-> lead_cnt == baud_div;
  endproperty
  property p_release;
    tx_stop_bit && sent |-> s_drop;
  endproperty
  property p_no_spont;
    $rose(ld) && $stable(cfg_q) |-> $past(tx_char_req, 2);
  endproperty
  property p_probe;
    $rose(usb.vbus) |=> dcp_probe_en;
  endproperty
  property p_susp;
    s_susp ##0 $stable(cfg_q) |-> (cio_out & (pwr_m | slp_m)) == pwr_m;
  endproperty
  property p_enum;
    usb.enumerated [*3] ##0 $stable(cfg_q) |->
      (cio_out & (pwr_m | slp_m | chg_m | chgn_m)) == (slp_m | chgn_m);
  endproperty
  property p_chg;
    dcp_cnt > 2010 && !bad && $stable(cfg_q) |->
      (cio_out & (chg_m | chgn_m | pwr_m)) == (chg_m | pwr_m);
  endproperty
  property p_led_on(t, oe, o);
    t |-> ##2 (oe && !o) [*4];
  endproperty
  property p_led_off(idle, oe);
    idle && $stable(cfg_q) |-> !oe;
  endproperty

  a_baud_floor: assert property (p_baud_floor) else $error("bit period too short");
  a_lead: assert property (p_lead) else $error("enable lead wrong");
  a_release: assert property (p_release) else $error("enable not released");
  a_no_spont: assert property (p_no_spont) else $error("enable without char");
  a_probe: assert property (p_probe) else $error("no charger probe");
  a_susp: assert property (p_susp) else $error("suspend pins wrong");
  a_enum: assert property (p_enum) else $error("active pins wrong");
  a_chg: assert property (p_chg) else $error("charger pins wrong");

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    logic [3:0] c;
    logic       t;
    int         q;
    assign c         = cfg_q[4*i+:4];
    assign ld_m[i]   = c == 4'h1;
    assign pwr_m[i]  = c == 4'h2;
    assign slp_m[i]  = c == 4'h3;
    assign chg_m[i]  = c == 4'h4;
    assign chgn_m[i] = c == 4'h5;
    assign t = (c == 4'h6 && tx_activity) || (c == 4'h7 && rx_activity)
            || (c == 4'h8 && (tx_activity || rx_activity));
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) q <= 0;
      else if (t) q <= 0;
      else if (q < LED_HOLD_CYC + 8) q <= q + 1;
    end
    a_led_on: assert property (p_led_on(t, cio_oe[i], cio_out[i])) else $error("led not lit");
    a_led_off: assert property (p_led_off(c inside {4'h6, 4'h7, 4'h8} && q > LED_HOLD_CYC + 3,
      cio_oe[i])) else $error("led not released");
  end
endmodule

bind cps_pins cps_pins_props #(.NUM_PINS(NUM_PINS), .LED_HOLD_CYC(LED_HOLD_CYC)) u_props (
  .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .tx_char_req(tx_char_req), .tx_stop_bit(tx_stop_bit), .tx_char_go(tx_char_go),
  .baud_div(baud_div), .tx_activity(tx_activity), .rx_activity(rx_activity), .usb(usb),
  .dcp_probe_en(dcp_probe_en), .cio_out(cio_out), .cio_oe(cio_oe));

// ---- dv/cps_far_side.sv ----
/*
  Far side of the pins: USB port (none, host, charging port) and pulled-up pin loads.
  Assumes every configurable pin load pulls high when the pin floats.
*/
`timescale 1ns/1ps
module cps_far_side #(
  parameter int NUM_PINS = 4
) (
  // Port selection
  input wire logic [1:0]          port_kind,
  input wire logic                host_susp,
  input wire logic                dcp_probe_en,
  // Pins
  input wire logic [NUM_PINS-1:0] cio_out,
  input wire logic [NUM_PINS-1:0] cio_oe,
  output cps_pkg::cps_usb_s       usb,
  output logic [NUM_PINS-1:0]     pin_level
);
  always_comb begin
    usb.vbus       = port_kind != 2'h0;
    usb.enumerated = port_kind == 2'h1 && !host_susp;
    usb.suspend    = port_kind == 2'h1 && host_susp;
    // A charging port shorts the data lines, so D- echoes the probe on D+.
    usb.dm_level   = port_kind == 2'h2 && dcp_probe_en;
    // LEDs and enables pull a floating pin high.
    pin_level      = (cio_oe & cio_out) | ~cio_oe;
  end
endmodule

// ---- dv/test_cps_pins.sv ----
/*
  Self-checking bench for the configurable status pins.
  Assumes the far-side model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module test_cps_pins;
  localparam int HOLD = 8;
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  cps_pkg::cps_reg_req_s reg_req = '0;
  logic                  tx_char_req = 1'b0, tx_stop_bit = 1'b0;
  logic                  tx_activity = 1'b0, rx_activity = 1'b0;
  logic [1:0]            port_kind = 2'h0;
  logic                  host_susp = 1'b0;
  logic [31:0]           reg_rdata, v;
  logic                  tx_char_go, dcp_probe_en;
  logic [15:0]           baud_div;
  logic [15:0]           cfg = 16'h3671;
  logic [3:0]            cio_out, cio_oe, pin_level;
  cps_pkg::cps_usb_s     usb;
  int                    mismatches = 0, n_checks = 0, cyc = 0, seed = 98893, t, tg, i, k;

  cps_pins #(.NUM_PINS(4), .LED_HOLD_CYC(HOLD)) u_cps_pins (
    .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .tx_char_req(tx_char_req), .tx_stop_bit(tx_stop_bit), .tx_char_go(tx_char_go),
    .baud_div(baud_div), .tx_activity(tx_activity), .rx_activity(rx_activity), .usb(usb),
    .dcp_probe_en(dcp_probe_en), .cio_out(cio_out), .cio_oe(cio_oe));
  cps_far_side #(.NUM_PINS(4)) u_cps_far_side (
    .port_kind(port_kind), .host_susp(host_susp), .dcp_probe_en(dcp_probe_en),
    .cio_out(cio_out), .cio_oe(cio_oe), .usb(usb), .pin_level(pin_level));

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // Tasks and pin model
  // ****************************************************************
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task ticks(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk) reg_req <= '0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk) reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge sys_clk) reg_req <= '0;
    #1 d = reg_rdata;
  endtask
  task set_cfg(input logic [15:0] c);
    cfg = c;
    wr(8'h00, {16'h0, c});
    ticks(2);
  endtask
  task act(input int src);
    @(posedge sys_clk) begin
      tx_activity <= src[0];
      rx_activity <= src[1];
    end
    @(posedge sys_clk) {tx_activity, rx_activity} <= 2'b00;
    ticks(1);
  endtask
  function automatic logic [1:0] exp_pin(input logic [3:0] c, input int ld, su, ch, tx, rx);
    case (c)
      4'h1: return {1'b1, 1'(ld)};
      4'h2: return {1'b1, 1'(su)};
      4'h3: return {1'b1, !1'(su)};
      4'h4: return {1'b1, 1'(ch)};
      4'h5: return {1'b1, !1'(ch)};
      4'h6: return {1'(tx), 1'b0};
      4'h7: return {1'(rx), 1'b0};
      4'h8: return {1'(tx | rx), 1'b0};
      default: return 2'b00;
    endcase
  endfunction
  task chk_pins(input int ld, su, ch, tx, rx);
    for (int p = 0; p < 4; p++) chk({cio_oe[p], cio_out[p]}, exp_pin(cfg[4*p+:4], ld, su, ch, tx, rx));
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    chk(baud_div, 32'd20833);
    rst <= 1'b0;
    ticks(2);
    chk_pins(0, 0, 0, 0, 0);
    $display("test reset done");
    rd(8'h00, v);
    chk(v, 32'h3671);
    rd(8'h0c, v);
    chk(v, 32'h0);
    for (i = 0; i < 6; i++) begin
      k = (i == 0) ? 3 : ($random(seed) & 16'hffff);
      wr(8'h04, k);
      rd(8'h04, v);
      chk(v, (k < 67) ? 67 : k);
    end
    wr(8'h04, 32'd70);
    $display("test bit period done");
    // Second request during the lead must be ignored, so one go is expected.
    @(posedge sys_clk) tx_char_req <= 1'b1;
    t = 0;
    tg = 0;
    for (k = 1; k <= 300; k++) begin
      ticks(1);
      if (k == 1 || k == 6) tx_char_req <= 1'b0;
      if (k == 5) tx_char_req <= 1'b1;
      if (t == 0 && cio_out[0] === 1'b1) t = k;
      if (tx_char_go === 1'b1) tg = (tg == 0) ? k : -1;
      if (k == 80) tx_stop_bit <= 1'b1;
      if (k == 81) begin
        tx_stop_bit <= 1'b0;
        chk(cio_out[0], 1);
      end
      if (k == 82) chk(cio_out[0], 0);
    end
    chk(t, 2);
    chk(tg, 72);
    chk_pins(0, 0, 0, 0, 0);
    $display("test line enable done");
    for (i = 0; i < 6; i++) begin
      set_cfg({8'h90, 4'(6 + i / 2), 4'h1});
      ticks($random(seed) & 3);
      act(1 + i % 2);
      chk_pins(0, 0, 0, i % 2 == 0, i % 2 == 1);
      ticks(HOLD + 4);
      chk_pins(0, 0, 0, 0, 0);
    end
    act(1);
    ticks(HOLD - 4);
    act(2);
    ticks(HOLD - 3);
    chk_pins(0, 0, 0, 1, 1);
    chk(pin_level[1], 0);
    $display("test activity done");
    set_cfg(16'h3245);
    @(posedge sys_clk) port_kind <= 2'h1;
    ticks(4);
    chk_pins(0, 0, 0, 0, 0);
    rd(8'h08, v);
    chk(v, 32'h10);
    @(posedge sys_clk) host_susp <= 1'b1;
    ticks(4);
    chk_pins(0, 1, 0, 0, 0);
    rd(8'h08, v);
    chk(v, 32'h1);
    @(posedge sys_clk) port_kind <= 2'h0;
    ticks(4);
    $display("test suspend done");
    @(posedge sys_clk) port_kind <= 2'h2;
    ticks(1000);
    chk_pins(0, 0, 0, 0, 0);
    ticks(1020);
    chk_pins(0, 1, 1, 0, 0);
    rd(8'h08, v);
    chk(v, 32'h7);
    $display("test charging port done");
    tally_and_finish();
  end
endmodule
